/* File: pkg/gpm_map.vh */
`ifndef GPM_MAP_VH
`define GPM_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GPM_OFS_OUT_ENABLE 12'h000
`define GPM_OFS_OUT_VALUE 12'h004
`define GPM_OFS_PIN_IN 12'h008
`define GPM_OFS_CURR_DAC 12'h00c
`define GPM_OFS_CONV_CFG 12'h010
`define GPM_OFS_STATUS 12'h014
`define GPM_OFS_PIN_CTRL0 12'h040
// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define GPM_NUM_PINS 15
`define GPM_MODE_W 3
`define GPM_MODE_INV_BIT 2
`define GPM_DIGIN8_BIT 0
`define GPM_CONV_CH_W 5
`define GPM_CONV_START_BIT 8
`define GPM_STAT_STARTUP_BIT 0
`define GPM_STAT_ID1_BIT 1
`define GPM_STAT_ID2_BIT 2
`define GPM_STAT_STEP_BIT 3
// ----------------------------------------
// Source select codes, low mode bits
// ----------------------------------------
`define GPM_SRC_SERIAL 2'h0
`define GPM_SRC_IRQ 2'h1
`define GPM_SRC_PWM1 2'h2
`define GPM_SRC_PWM2 2'h3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPM_RST_OUT_ENABLE 15'h0000
`define GPM_RST_MODE 3'h0
`endif

/* File: src/gpm_pin0_mux.v */
`default_nettype none
`include "gpm_map.vh"
// Pin 0 output multiplexer, open drain pull-down enable
module gpm_pin0_mux (
    input wire startup_state,
    input wire out_enable,
    input wire [2:0] mode,
    input wire serial_value,
    input wire irq_controller_output,
    input wire aux_pwm_one,
    input wire aux_pwm_two,
    output reg pull_low
);
    reg src;
    reg level;
    // Source select, inversion, open drain
    always @* begin
        case (mode[1:0])
            `GPM_SRC_SERIAL: src = serial_value;
            `GPM_SRC_IRQ: src = irq_controller_output;
            `GPM_SRC_PWM1: src = aux_pwm_one;
            default: src = aux_pwm_two;
        endcase
        level = mode[`GPM_MODE_INV_BIT] ? ~src : src;
        pull_low = ~startup_state & out_enable & ~level;
    end
endmodule
`default_nettype wire

/* File: src/gpm_step_detect.v */
`default_nettype none
// Rising-edge detector for the step request input
module gpm_step_detect (
    input wire hclk,
    input wire hresetn,
    input wire enable,
    input wire level_in,
    output reg step_pulse
);
    reg last;
    // Edge on enabled input yields one step
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last <= 1'b1; // Pin idles high through its pull-up, no false edge after reset
            step_pulse <= 1'b0;
        end else begin
            last <= level_in;
            step_pulse <= enable & level_in & ~last;
        end
    end
endmodule
`default_nettype wire

/* File: src/gpm_gpio_pin_function_mux.v */
// Contract
// - A pin drives output only when its output enable bit is set; here pin 5 in master mode follows slave_control regardless of it.
// - Each pin has its own three-bit function select in its control register.
// - Pin 8 digital input stays off after reset until software enables it.
// - While startup state is 1, pin 0 only detects startup configuration.
// - Startup 0 and enable 0 leave pin 0 floating; level always readable.
// - Low mode bits pick serial value, interrupt, PWM one or PWM two.
// - High mode bit inverts the chosen source.
// - Pin 0 voltage can be converted even while output is enabled.
// - Pin 0 is open drain: pulls low only.
// - Serial output function follows the software-written pin value.
// - Step request input activity advances stepper sequencer one step.
// - Identification bits one and two come from strap pin levels.
// - As master, the designated pin controls a secondary device.
// - Conversion status pin shows status of current conversion.
// - Auxiliary PWM function outputs the matching generator waveform.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`default_nettype none
`include "gpm_map.vh"
module gpm_gpio_pin_function_mux #(
    parameter NUM_PINS = `GPM_NUM_PINS,
    parameter ID1_PIN = 9,
    parameter ID2_PIN = 10,
    parameter STEP_PIN = 12,
    parameter EXT_PWM_PIN = 2,
    parameter SLAVE_PIN = 5,
    parameter STATUS_PIN = 6
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [14:0] pin_in,
    output reg [14:0] pin_out,
    output reg [14:0] pin_oe,
    input wire startup_done,
    input wire master_mode,
    input wire slave_control,
    input wire irq_controller_output,
    input wire aux_pwm_one,
    input wire aux_pwm_two,
    input wire conversion_status_out,
    output reg [4:0] conversion_channel_select,
    output reg conversion_start,
    output reg step_request,
    output reg ext_pwm_to_bridges,
    output reg ident_strap_one,
    output reg ident_strap_two
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg [14:0] pin_output_enable_vector;
    reg [14:0] out_value;
    reg [2:0] pin_function_select [0:14];
    reg pin8_digital_input_enable;
    reg startup_state;
    reg [4:0] conv_ch;
    reg wr_pend;
    reg [11:0] wr_addr;
    wire [14:0] pin_read;
    wire pin0_pull_low;
    wire step_pulse;
    integer k;
    integer j;

    // Index of a pin control register, or 15 when not one
    function [3:0] ctrl_index;
        input [11:0] a;
        begin
            if (a >= `GPM_OFS_PIN_CTRL0 && a < `GPM_OFS_PIN_CTRL0 + 12'h03c && a[1:0] == 2'h0) begin
                ctrl_index = a[5:2];
            end else begin
                ctrl_index = 4'hf;
            end
        end
    endfunction

    // Pin 8 input buffer gated; others read raw
    assign pin_read = {pin_in[14:9], pin_in[8] & pin8_digital_input_enable, pin_in[7:0]};

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    gpm_pin0_mux u_pin0 (
        .startup_state(startup_state),
        .out_enable(pin_output_enable_vector[0]),
        .mode(pin_function_select[0]),
        .serial_value(out_value[0]),
        .irq_controller_output(irq_controller_output),
        .aux_pwm_one(aux_pwm_one),
        .aux_pwm_two(aux_pwm_two),
        .pull_low(pin0_pull_low)
    );

    gpm_step_detect u_step (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(~pin_output_enable_vector[STEP_PIN]),
        .level_in(pin_in[STEP_PIN]),
        .step_pulse(step_pulse)
    );

    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready) begin
                wr_pend <= hsel & htrans[1] & hwrite;
                wr_addr <= haddr[11:0];
                hrdata <= 32'h00000000;
                if (hsel & htrans[1] & ~hwrite) begin
                    case (haddr[11:0])
                        `GPM_OFS_OUT_ENABLE: hrdata <= {17'h00000, pin_output_enable_vector};
                        `GPM_OFS_OUT_VALUE: hrdata <= {17'h00000, out_value};
                        `GPM_OFS_PIN_IN: hrdata <= {17'h00000, pin_read};
                        `GPM_OFS_CURR_DAC: hrdata <= {31'h00000000, pin8_digital_input_enable};
                        `GPM_OFS_CONV_CFG: hrdata <= {27'h0000000, conv_ch};
                        `GPM_OFS_STATUS: hrdata <= {28'h0000000, step_request, ident_strap_two,
                                                    ident_strap_one, startup_state};
                        default: begin
                            if (ctrl_index(haddr[11:0]) != 4'hf) begin
                                hrdata <= {29'h00000000, pin_function_select[ctrl_index(haddr[11:0])]};
                            end
                        end
                    endcase
                end
            end
        end
    end

    // Register writes in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_output_enable_vector <= `GPM_RST_OUT_ENABLE;
            out_value <= 15'h0000;
            pin8_digital_input_enable <= 1'b0;
            conv_ch <= 5'h00;
            conversion_start <= 1'b0;
            for (k = 0; k < NUM_PINS; k = k + 1) begin
                pin_function_select[k] <= `GPM_RST_MODE;
            end
        end else begin
            conversion_start <= 1'b0;
            if (wr_pend) begin
                case (wr_addr)
                    `GPM_OFS_OUT_ENABLE: pin_output_enable_vector <= hwdata[14:0];
                    `GPM_OFS_OUT_VALUE: out_value <= hwdata[14:0];
                    `GPM_OFS_CURR_DAC: pin8_digital_input_enable <= hwdata[`GPM_DIGIN8_BIT];
                    `GPM_OFS_CONV_CFG: begin
                        conv_ch <= hwdata[4:0];
                        conversion_start <= hwdata[`GPM_CONV_START_BIT];
                    end
                    default: begin
                        if (ctrl_index(wr_addr) != 4'hf) begin
                            pin_function_select[ctrl_index(wr_addr)] <= hwdata[2:0];
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Startup state and pin side
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            startup_state <= 1'b1;
            pin_out <= 15'h0000;
            pin_oe <= 15'h0000;
            conversion_channel_select <= 5'h00;
            step_request <= 1'b0;
            ext_pwm_to_bridges <= 1'b0;
            ident_strap_one <= 1'b0;
            ident_strap_two <= 1'b0;
        end else begin
            if (startup_done) begin
                startup_state <= 1'b0;
            end
            pin_out <= 15'h0000;
            pin_oe[0] <= pin0_pull_low;
            for (j = 1; j < NUM_PINS; j = j + 1) begin
                if (j == SLAVE_PIN && master_mode) begin
                    pin_oe[j] <= ~slave_control;
                end else if (j == STATUS_PIN) begin
                    pin_oe[j] <= pin_output_enable_vector[j] & ~conversion_status_out;
                end else begin
                    pin_oe[j] <= pin_output_enable_vector[j] & ~out_value[j];
                end
            end
            conversion_channel_select <= conv_ch;
            step_request <= step_pulse;
            ext_pwm_to_bridges <= pin_in[EXT_PWM_PIN];
            ident_strap_one <= pin_in[ID1_PIN];
            ident_strap_two <= pin_in[ID2_PIN];
        end
    end
endmodule
`default_nettype wire

/* File: verification/gpm_assertions.sv */
`default_nettype none
// Port checks for the pin function block
module gpm_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [14:0] pin_in,
    input wire logic [14:0] pin_out,
    input wire logic [14:0] pin_oe,
    input wire logic startup_done,
    input wire logic master_mode,
    input wire logic slave_control,
    input wire logic conversion_start,
    input wire logic step_request,
    input wire logic ext_pwm_to_bridges,
    input wire logic ident_strap_one,
    input wire logic ident_strap_two
);
    timeunit 1ns;
    timeprecision 100ps;
    logic seen;
    // Sticky record of startup completion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) seen <= 1'b0;
        else if (startup_done) seen <= 1'b1;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_BUS_OK: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_OPEN_DRAIN: assert property (pin_out == 15'h0000)
        else $error("pin driven high");
    AST_STARTUP: assert property (!seen |-> !pin_oe[0])
        else $error("pin 0 driven during startup");
    AST_STEP: assert property (step_request |-> $past(pin_in[12], 2) && !$past(pin_in[12], 3))
        else $error("step without rising edge");
    AST_STEP_PULSE: assert property (step_request |=> !step_request)
        else $error("step request longer than one cycle");
    AST_IDENT: assert property ($past(hresetn) |-> {ident_strap_two, ident_strap_one} == $past(pin_in[10:9]))
        else $error("ident bits differ from strap pins");
    AST_EXT_PWM: assert property ($past(hresetn) |-> ext_pwm_to_bridges == $past(pin_in[2]))
        else $error("external pwm not routed");
    AST_MASTER: assert property ($past(hresetn) && $past(master_mode) |-> pin_oe[5] == !$past(slave_control))
        else $error("slave control pin wrong");
    AST_CONV_PULSE: assert property (conversion_start |=> !conversion_start)
        else $error("conversion start longer than one cycle");
endmodule
bind gpm_gpio_pin_function_mux gpm_chk gpm_chk_i (.hclk, .hresetn, .hreadyout, .hresp, .pin_in, .pin_out,
    .pin_oe, .startup_done, .master_mode, .slave_control, .conversion_start, .step_request,
    .ext_pwm_to_bridges, .ident_strap_one, .ident_strap_two);
`default_nettype wire

/* File: verification/gpm_pins.sv */
`default_nettype none
// Board side of the pins: pull-ups and external open-drain pullers
module gpm_pins (
    input wire logic [14:0] pin_oe,
    input wire logic [14:0] ext_low,
    output logic [14:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Wired-and level, released pins float high
    assign pin_in = ~(pin_oe | ext_low);
endmodule
`default_nettype wire

/* File: verification/gpm_gpio_pin_function_mux_tb.sv */
`default_nettype none
`include "gpm_map.vh"
module gpm_gpio_pin_function_mux_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, startup_done = 1'b0;
    logic master_mode = 1'b0, slave_control = 1'b0, irq_controller_output = 1'b0;
    logic aux_pwm_one = 1'b0, aux_pwm_two = 1'b0, conversion_status_out = 1'b0, lv;
    logic hreadyout, hresp, conversion_start, step_request, ext_pwm_to_bridges, ident_strap_one, ident_strap_two;
    logic [1:0] htrans = 2'h0, sel;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [14:0] pin_in, pin_out, pin_oe, ext_low = 15'h0;
    logic [4:0] conversion_channel_select;
    int err_total = 0, checks_done = 0, cyc = 0, steps = 0, starts = 0, base;
    gpm_gpio_pin_function_mux gpm_gpio_pin_function_mux_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe,
        .startup_done, .master_mode, .slave_control, .irq_controller_output, .aux_pwm_one, .aux_pwm_two,
        .conversion_status_out, .conversion_channel_select, .conversion_start, .step_request,
        .ext_pwm_to_bridges, .ident_strap_one, .ident_strap_two);
    gpm_pins gpm_pins_i (.pin_oe, .ext_low, .pin_in);
    always #2.5 hclk = ~hclk;
    // Watchdog and pulse counters
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (step_request === 1'b1) steps <= steps + 1;
        if (conversion_start === 1'b1) starts <= starts + 1;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end
    // One single AHB transfer, read data left in rd
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    task complete_run();
        if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, `GPM_OFS_OUT_ENABLE, 32'h1);
        repeat (3) @(posedge hclk);
        chk(pin_oe, 32'h0);
        startup_done <= 1'b1;
        bus(1'b0, `GPM_OFS_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0);
        // Every pin 0 function, other sources at the opposite level
        for (int m = 0; m < 8; m++) begin
            for (int v = 0; v < 2; v++) begin
                sel = m[1:0];
                lv = v[0];
                bus(1'b1, `GPM_OFS_PIN_CTRL0, m);
                bus(1'b1, `GPM_OFS_OUT_VALUE, {31'h0, lv ^ (sel != 2'h0)});
                irq_controller_output <= lv ^ (sel != 2'h1);
                aux_pwm_one <= lv ^ (sel != 2'h2);
                aux_pwm_two <= lv ^ (sel != 2'h3);
                repeat (3) @(posedge hclk);
                chk({31'h0, pin_oe[0]}, {31'h0, !(m[2] ^ lv)});
                bus(1'b0, `GPM_OFS_PIN_IN, 32'h0);
                chk(rd & 32'h1, {31'h0, m[2] ^ lv});
            end
        end
        bus(1'b1, `GPM_OFS_OUT_ENABLE, 32'h0);
        repeat (3) @(posedge hclk);
        chk(pin_oe, 32'h0);
        bus(1'b1, `GPM_OFS_OUT_VALUE, 32'h0);
        bus(1'b1, `GPM_OFS_OUT_ENABLE, 32'h7fff);
        repeat (3) @(posedge hclk);
        chk(pin_oe, 32'h7fff);
        bus(1'b1, `GPM_OFS_OUT_VALUE, 32'h7fff);
        repeat (3) @(posedge hclk);
        chk(pin_oe & 15'h7fbf, 32'h1);
        conversion_status_out <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(pin_oe, 32'h1);
        // Pin 8 input buffer off until enabled
        bus(1'b1, `GPM_OFS_OUT_ENABLE, 32'h0);
        bus(1'b0, `GPM_OFS_PIN_IN, 32'h0);
        chk(rd & 32'h100, 32'h0);
        bus(1'b1, `GPM_OFS_CURR_DAC, 32'h1);
        bus(1'b0, `GPM_OFS_PIN_IN, 32'h0);
        chk(rd & 32'h100, 32'h100);
        // Step input counted only while its output is off
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, `GPM_OFS_OUT_ENABLE, {19'h0, k[0], 12'h0});
            base = steps;
            ext_low[12] <= 1'b1;
            repeat (3) @(posedge hclk);
            ext_low[12] <= 1'b0;
            repeat (5) @(posedge hclk);
            chk(steps - base, 1 - k);
        end
        ext_low <= 15'h0204;
        bus(1'b1, `GPM_OFS_OUT_ENABLE, 32'h1);
        chk({ident_strap_two, ident_strap_one, ext_pwm_to_bridges}, 32'h4);
        bus(1'b0, `GPM_OFS_STATUS, 32'h0);
        chk(rd & 32'h6, 32'h4);
        base = starts;
        bus(1'b1, `GPM_OFS_CONV_CFG, 32'h113);
        repeat (3) @(posedge hclk);
        chk(conversion_channel_select, 32'h13);
        chk(starts - base, 1);
        bus(1'b0, `GPM_OFS_CONV_CFG, 32'h0);
        chk(rd, 32'h13);
        master_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(pin_oe[5], 32'h1);
        slave_control <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(pin_oe[5], 32'h0);
        bus(1'b1, 32'h0f00, 32'hffff_ffff);
        bus(1'b0, 32'h0f00, 32'h0);
        chk(rd, 32'h0);
        // Each pin keeps its own function field
        bus(1'b1, 32'h0078, 32'h5);
        bus(1'b0, 32'h0078, 32'h0);
        chk(rd, 32'h5);
        bus(1'b0, `GPM_OFS_PIN_CTRL0, 32'h0);
        chk(rd, 32'h7);
        complete_run();
    end
endmodule
`default_nettype wire
